// ==== epp_pkg.sv ====
package epp_pkg;
  // =============================================
  // parameter sub-indices (register select codes)
  localparam logic [7:0]  SI_SUPPLY   = 8'h01;
  localparam logic [7:0]  SI_TYPE     = 8'h02;
  localparam logic [7:0]  SI_LINES    = 8'h03;
  localparam logic [7:0]  SI_DIR      = 8'h04;
  localparam logic [7:0]  SI_RES      = 8'h05;
  localparam logic [7:0]  SI_NBITS    = 8'h06;
  localparam logic [7:0]  SI_CODING   = 8'h07;
  localparam logic [7:0]  SI_MASK     = 8'h08;
  localparam logic [7:0]  SI_OFFSET   = 8'h09;
  localparam logic [7:0]  SI_POS      = 8'h0A;
  localparam logic [7:0]  SI_ANGLE    = 8'h0B;
  localparam logic [7:0]  SI_STORE    = 8'h0E;
  localparam logic [7:0]  SI_DATUM    = 8'h0F;
  // =============================================
  // reset values
  localparam logic [7:0]  RST_SUPPLY  = 8'h05;
  localparam logic [7:0]  RST_TYPE    = 8'h00;
  localparam logic [31:0] RST_LINES   = 32'h00000400;
  localparam logic [7:0]  RST_DIR     = 8'h00;
  localparam logic [7:0]  RST_RES     = 8'h0A;
  localparam logic [7:0]  RST_NBITS   = 8'h0D;
  localparam logic [7:0]  RST_CODING  = 8'h00;
  localparam logic [31:0] RST_MASK    = 32'hFFFFFFFC;
  localparam logic [31:0] RST_OFFSET  = 32'h00000000;
  localparam logic [7:0]  RST_STORE   = 8'h00;
  localparam logic [31:0] RST_DATUM   = 32'h00000000;
  // =============================================
  // legal values
  localparam logic [7:0]  SUP_5V      = 8'h05;
  localparam logic [7:0]  SUP_8V      = 8'h08;
  localparam logic [7:0]  SUP_12V     = 8'h0C;
  localparam logic [7:0]  TYPE_MAX    = 8'h05;
  localparam logic [7:0]  TYPE_DIG    = 8'h01;
  localparam logic [7:0]  TYPE_ANA    = 8'h02;
  localparam logic [7:0]  TYPE_SSI    = 8'h03;
  localparam logic [7:0]  RES_MIN     = 8'h02;
  localparam logic [7:0]  RES_MAX     = 8'h1F;
  localparam logic [7:0]  NBITS_MIN   = 8'h02;
  localparam logic [7:0]  NBITS_MAX   = 8'h20;
  localparam logic [7:0]  CODE_GRAY   = 8'h00;
  // =============================================
  // timing
  localparam int          CLK_NS      = 5;
  localparam int          LINK_NS     = 64;
  localparam int          SSI_HALF_NS = 256;
  localparam int          SSI_HALF_CYC = (SSI_HALF_NS + LINK_NS - 1) / LINK_NS;
  localparam int          MONO_NS     = 20000;
  localparam int          MONO_CYC    = (MONO_NS + LINK_NS - 1) / LINK_NS;
  localparam int          VEL_NS      = 1000000;
  localparam int          VEL_CYC     = VEL_NS / CLK_NS;

  typedef enum logic [1:0] {L_IDLE, L_SHIFT, L_GAP} epp_link_t;
endpackage

// ==== epp_top.sv ====
`timescale 1ns/1ps
module epp_top
  import epp_pkg::*;
#(
  parameter int VEL_CYCLES  = VEL_CYC,
  parameter int MONO_CYCLES = MONO_CYC
) (
  // clocks and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        link_clk_in,
  // parameter port
  input  wire logic [7:0]  par_sel_in,
  input  wire logic        par_wr_in,
  input  wire logic [31:0] par_wdata_in,
  output logic      [31:0] par_rdata_out,
  output logic             par_err_out,
  // encoder pins
  input  wire logic        quad_a_in,
  input  wire logic        quad_b_in,
  input  wire logic [15:0] interp_frac_in,
  output logic             ssi_clk_out,
  input  wire logic        ssi_data_in,
  // drive side
  input  wire logic        store_req_in,
  output logic      [31:0] position_out,
  output logic      [31:0] velocity_out,
  output logic      [15:0] rotor_angle_out,
  output logic      [7:0]  supply_sel_out,
  output logic      [31:0] datum_value_out,
  output logic             store_enable_out,
  output logic             store_go_out
);

  // gap counter is nine bits wide
  if (VEL_CYCLES < 1 || MONO_CYCLES < 1 || MONO_CYCLES > 512) begin : g_bad
    $error("epp_top: cycle counts out of range");
  end

  // =============================================
  // helpers
  function automatic logic [31:0] len_mask(input logic [7:0] n);
    len_mask = (n >= NBITS_MAX) ? 32'hFFFFFFFF : ((32'h00000001 << n[4:0]) - 32'h00000001);
  endfunction

  function automatic logic [31:0] compact(input logic [31:0] raw, input logic [31:0] sel);
    logic [31:0] r;
    logic [5:0]  j;
    r = 32'h00000000;
    j = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (sel[i]) begin
        r[j[4:0]] = raw[i];
        j = j + 6'h01;
      end
    end
    compact = r;
  endfunction

  function automatic logic [31:0] gray2bin(input logic [31:0] g);
    logic [31:0] b;
    b = 32'h00000000;
    b[31] = g[31];
    for (int i = 30; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // one revolution maps to the full 16-bit range
  function automatic logic [15:0] angle_of(input logic [31:0] v, input logic [31:0] per);
    logic [47:0] t;
    t = 48'h000000000000;
    if (per != 32'h00000000) begin
      t = {16'h0000, v % per} << 16;
      t = t / {16'h0000, per};
    end
    angle_of = t[15:0];
  endfunction

  // =============================================
  // parameter registers
  logic [7:0]  supply_q, type_q, dir_q, res_q, nbits_q, coding_q, store_q;
  logic [31:0] lines_q, mask_q, off_q, datum_q;
  logic        wr_bad, err_q, go_q;
  logic [31:0] rdata_q, pos_q, vel_q, raw_dir_q;
  logic [15:0] angle_q;

  always_comb begin
    wr_bad = 1'b0;
    case (par_sel_in)
      SI_SUPPLY: wr_bad = !(par_wdata_in[7:0] inside {SUP_5V, SUP_8V, SUP_12V});
      SI_TYPE:   wr_bad = par_wdata_in[7:0] > TYPE_MAX;
      SI_DIR:    wr_bad = par_wdata_in[7:1] != 7'h00;
      SI_RES:    wr_bad = par_wdata_in[7:0] < RES_MIN || par_wdata_in[7:0] > RES_MAX;
      SI_NBITS:  wr_bad = par_wdata_in[7:0] < NBITS_MIN || par_wdata_in[7:0] > NBITS_MAX;
      SI_CODING: wr_bad = par_wdata_in[7:1] != 7'h00;
      SI_STORE:  wr_bad = par_wdata_in[7:1] != 7'h00;
      SI_LINES, SI_MASK, SI_OFFSET, SI_DATUM: wr_bad = 1'b0;
      default:   wr_bad = 1'b1;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      supply_q <= RST_SUPPLY;
      type_q   <= RST_TYPE;
      lines_q  <= RST_LINES;
      dir_q    <= RST_DIR;
      res_q    <= RST_RES;
      nbits_q  <= RST_NBITS;
      coding_q <= RST_CODING;
      mask_q   <= RST_MASK;
      off_q    <= RST_OFFSET;
      store_q  <= RST_STORE;
      datum_q  <= RST_DATUM;
    end else if (par_wr_in && !wr_bad) begin
      case (par_sel_in)
        SI_SUPPLY: supply_q <= par_wdata_in[7:0];
        SI_TYPE:   type_q   <= par_wdata_in[7:0];
        SI_LINES:  lines_q  <= par_wdata_in;
        SI_DIR:    dir_q    <= par_wdata_in[7:0];
        SI_RES:    res_q    <= par_wdata_in[7:0];
        SI_NBITS:  nbits_q  <= par_wdata_in[7:0];
        SI_CODING: coding_q <= par_wdata_in[7:0];
        SI_MASK:   mask_q   <= par_wdata_in;
        SI_OFFSET: off_q    <= par_wdata_in;
        SI_STORE:  store_q  <= par_wdata_in[7:0];
        SI_DATUM:  datum_q  <= par_wdata_in;
        default:   off_q    <= off_q;
      endcase
    end
  end

  // read-only entries refuse writes; answer is a one-cycle error pulse
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      err_q   <= 1'b0;
      rdata_q <= 32'h00000000;
      go_q    <= 1'b0;
    end else begin
      err_q <= par_wr_in && wr_bad;
      go_q  <= store_req_in && store_q == 8'h01;
      case (par_sel_in)
        SI_SUPPLY: rdata_q <= {24'h000000, supply_q};
        SI_TYPE:   rdata_q <= {24'h000000, type_q};
        SI_LINES:  rdata_q <= lines_q;
        SI_DIR:    rdata_q <= {24'h000000, dir_q};
        SI_RES:    rdata_q <= {24'h000000, res_q};
        SI_NBITS:  rdata_q <= {24'h000000, nbits_q};
        SI_CODING: rdata_q <= {24'h000000, coding_q};
        SI_MASK:   rdata_q <= mask_q;
        SI_OFFSET: rdata_q <= off_q;
        SI_POS:    rdata_q <= pos_q;
        SI_ANGLE:  rdata_q <= {16'h0000, angle_q};
        SI_STORE:  rdata_q <= {24'h000000, store_q};
        SI_DATUM:  rdata_q <= datum_q;
        default:   rdata_q <= 32'h00000000;
      endcase
    end
  end

  // =============================================
  // quadrature counting
  logic       a_s1, a_s2, a_p, b_s1, b_s2, b_p;
  logic       step, up;
  logic [31:0] per4, cnt_q, rev_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      {a_s1, a_s2, a_p, b_s1, b_s2, b_p} <= 6'h00;
    end else begin
      {a_s1, a_s2, a_p} <= {quad_a_in, a_s1, a_s2};
      {b_s1, b_s2, b_p} <= {quad_b_in, b_s1, b_s2};
    end
  end

  // double changes are illegal and dropped
  assign step = (a_s2 ^ a_p) ^ (b_s2 ^ b_p);
  assign up   = (a_p ^ b_s2) ^ dir_q[0];
  assign per4 = {lines_q[29:0], 2'b00};

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 32'h00000000;
      rev_q <= 32'h00000000;
    end else if (step && (type_q == TYPE_DIG || type_q == TYPE_ANA)) begin
      if (up) begin
        cnt_q <= (cnt_q + 32'h00000001 >= per4) ? 32'h00000000 : cnt_q + 32'h00000001;
        rev_q <= (cnt_q + 32'h00000001 >= per4) ? rev_q + 32'h00000001 : rev_q;
      end else begin
        cnt_q <= (cnt_q == 32'h00000000) ? per4 - 32'h00000001 : cnt_q - 32'h00000001;
        rev_q <= (cnt_q == 32'h00000000) ? rev_q - 32'h00000001 : rev_q;
      end
    end
  end

  // =============================================
  // serial link (link clock domain)
  logic        lrst_1, lrst_q, dat_s1, dat_s2, sclk_q, tog_q;
  logic [7:0]  nb_s1, nb_s2, nb_s3, nb_l;
  logic [31:0] sh_q, frame_q;
  logic [8:0]  ph_q;
  logic [5:0]  bit_q;
  epp_link_t   lst_q;

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {lrst_1, lrst_q} <= 2'b11;
    end else begin
      {lrst_1, lrst_q} <= {1'b0, lrst_1};
    end
  end

  // frame length is quasi-static; taken only when two samples agree
  always_ff @(posedge link_clk_in or posedge lrst_q) begin
    if (lrst_q) begin
      {dat_s1, dat_s2} <= 2'b11;
      {nb_s1, nb_s2, nb_s3} <= {RST_NBITS, RST_NBITS, RST_NBITS};
    end else begin
      {dat_s1, dat_s2} <= {ssi_data_in, dat_s1};
      {nb_s1, nb_s2, nb_s3} <= {nbits_q, nb_s1, nb_s2};
    end
  end

  always_ff @(posedge link_clk_in or posedge lrst_q) begin
    if (lrst_q) begin
      lst_q   <= L_IDLE;
      sclk_q  <= 1'b1;
      ph_q    <= 9'h000;
      bit_q   <= 6'h00;
      sh_q    <= 32'h00000000;
      frame_q <= 32'h00000000;
      tog_q   <= 1'b0;
      nb_l    <= RST_NBITS;
    end else begin
      case (lst_q)
        L_IDLE: begin
          if (nb_s2 == nb_s3) begin
            nb_l   <= nb_s3;
            sclk_q <= 1'b0;
            ph_q   <= 9'h000;
            bit_q  <= 6'h00;
            sh_q   <= 32'h00000000;
            lst_q  <= L_SHIFT;
          end
        end
        L_SHIFT: begin
          if (ph_q == 9'(SSI_HALF_CYC - 1)) begin
            ph_q <= 9'h000;
            if (sclk_q) begin
              sh_q  <= {sh_q[30:0], dat_s2};
              bit_q <= bit_q + 6'h01;
              if ({2'b00, bit_q} + 8'h01 == nb_l) begin
                frame_q <= {sh_q[30:0], dat_s2};
                tog_q   <= ~tog_q;
                lst_q   <= L_GAP;
              end else begin
                sclk_q <= 1'b0;
              end
            end else begin
              sclk_q <= 1'b1;
            end
          end else begin
            ph_q <= ph_q + 9'h001;
          end
        end
        L_GAP: begin
          // clock stays high so the encoder monoflop can expire
          if (ph_q == 9'(MONO_CYCLES - 1)) begin
            lst_q <= L_IDLE;
          end else begin
            ph_q <= ph_q + 9'h001;
          end
        end
        default: lst_q <= L_IDLE;
      endcase
    end
  end

  // =============================================
  // frame handover and decode (system domain)
  logic        t_s1, t_s2, t_p;
  logic [31:0] rawf_q, eff_w, comp_w, dec_w, ssi_q, raw_w;
  logic [15:0] frac_w;
  logic [4:0]  fsh;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      {t_s1, t_s2, t_p} <= 3'b000;
      rawf_q <= 32'h00000000;
      ssi_q  <= 32'h00000000;
    end else begin
      {t_s1, t_s2, t_p} <= {tog_q, t_s1, t_s2};
      if (t_s2 ^ t_p) begin
        rawf_q <= frame_q;
      end
      ssi_q <= dec_w;
    end
  end

  assign eff_w  = mask_q & len_mask(nbits_q);
  assign comp_w = compact(rawf_q, eff_w);
  assign dec_w  = (coding_q == CODE_GRAY) ? gray2bin(comp_w) : comp_w;

  // fraction sits below the whole-count bit position
  assign fsh    = 5'(res_q - RES_MIN);
  assign frac_w = dir_q[0] ? 16'h0000 - interp_frac_in : interp_frac_in;

  always_comb begin
    raw_w = 32'(rev_q * per4 + cnt_q) << fsh;
    if (type_q == TYPE_ANA && fsh != 5'h00) begin
      raw_w = raw_w | ((fsh >= 5'h10) ? 32'({frac_w, 16'h0000} >> (6'h20 - {1'b0, fsh}))
                                      : 32'(frac_w >> (5'h10 - fsh)));
    end
    if (type_q == TYPE_SSI) begin
      raw_w = dir_q[0] ? 32'h00000000 - ssi_q : ssi_q;
    end
  end

  // =============================================
  // outputs
  logic [31:0] vcnt_q, vprev_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      raw_dir_q <= 32'h00000000;
      pos_q     <= 32'h00000000;
      angle_q   <= 16'h0000;
    end else begin
      raw_dir_q <= raw_w;
      pos_q     <= raw_dir_q - off_q;
      if (type_q == TYPE_SSI) begin
        angle_q <= dir_q[0] ? 16'h0000 - angle_of(ssi_q, lines_q) : angle_of(ssi_q, lines_q);
      end else begin
        angle_q <= angle_of(cnt_q, per4);
      end
    end
  end

  // velocity is the position change per sample period
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      vcnt_q  <= 32'h00000000;
      vprev_q <= 32'h00000000;
      vel_q   <= 32'h00000000;
    end else if (vcnt_q == 32'(VEL_CYCLES - 1)) begin
      vcnt_q  <= 32'h00000000;
      vprev_q <= pos_q;
      vel_q   <= pos_q - vprev_q;
    end else begin
      vcnt_q <= vcnt_q + 32'h00000001;
    end
  end

  assign par_rdata_out    = rdata_q;
  assign par_err_out      = err_q;
  assign position_out     = pos_q;
  assign velocity_out     = vel_q;
  assign rotor_angle_out  = angle_q;
  assign supply_sel_out   = supply_q;
  assign datum_value_out  = datum_q;
  assign store_enable_out = store_q[0];
  assign store_go_out     = go_q;
  assign ssi_clk_out      = sclk_q;

  // =============================================
  // checks
  offset_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (par_wr_in && par_sel_in == SI_OFFSET && par_wdata_in == raw_dir_q) ##1 (raw_dir_q == $past(raw_dir_q))
    |=> pos_q == 32'h00000000) else $error("offset did not zero position");
  count_up_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (step && !dir_q[0] && (a_p ^ b_s2) && type_q == TYPE_DIG && cnt_q + 32'h00000001 < per4)
    |=> cnt_q == $past(cnt_q) + 32'h00000001) else $error("B leading A did not count up");
  count_rev_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (step && dir_q[0] && (a_p ^ b_s2) && type_q == TYPE_DIG && cnt_q != 32'h00000000)
    |=> cnt_q == $past(cnt_q) - 32'h00000001) else $error("reversed count went wrong way");
  ssi_dir_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (type_q == TYPE_SSI && dir_q[0]) ##1 (type_q == TYPE_SSI && dir_q[0])
    |-> raw_dir_q == 32'h00000000 - $past(ssi_q)) else $error("serial reversal missing");
  frame_len_a: assert property (@(posedge link_clk_in) disable iff (lrst_q)
    (lst_q == L_GAP && $changed(tog_q)) |-> ({2'b00, bit_q} == nb_l)) else $error("frame length wrong");
  gray_dec_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (coding_q == CODE_GRAY) |-> (dec_w[0] == ^comp_w && dec_w[31] == comp_w[31])) else $error("gray decode wrong");
  mask_lsb_a: assert property (@(posedge clock_in) disable iff (rst_in)
    eff_w[0] |-> comp_w[0] == rawf_q[0]) else $error("mask bit zero misaligned");
  mask_len_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $countones(eff_w) <= nbits_q) else $error("mask bit beyond frame used");
  angle_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (type_q == TYPE_DIG && cnt_q == 32'h00000000) |=> angle_q == 16'h0000)
    else $error("angle not zero at count zero");
  datum_wr_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (par_wr_in && par_sel_in == SI_DATUM) |=> datum_value_out == $past(par_wdata_in)) else $error("datum not held");
  store_gate_a: assert property (@(posedge clock_in) disable iff (rst_in)
    store_go_out |-> $past(store_q) == 8'h01) else $error("store without enable");
  every_edge_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (step && type_q == TYPE_DIG) |=> cnt_q != $past(cnt_q) || per4 == 32'h00000000) else $error("edge not counted");

endmodule

// ==== epp_enc_model.sv ====
`timescale 1ns/1ps
// =============================================
// encoder model: quadrature pins and serial absolute frames
module epp_enc_model #(
  // high time that ends a frame; above one half bit, below the bench's frame gap
  parameter int IDLE_NS = 400
) (
  // serial link
  input  wire logic        ssi_clk_in,
  output logic             ssi_data_out,
  // frame setup from the bench
  input  wire logic [31:0] frame_in,
  input  wire logic [7:0]  nbits_in,
  // quadrature pins
  output logic             quad_a_out,
  output logic             quad_b_out
);
  logic [1:0]  seq [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  int unsigned phase_q = 0;
  int          bit_idx = -1;
  logic [31:0] word_q  = 32'h0;
  realtime     rise_t  = 0.0;

  initial begin
    ssi_data_out = 1'b1;
    {quad_a_out, quad_b_out} = 2'b00;
  end

  // =============================================
  // one edge per call, b leads a going up; spacing well above the synchroniser's need
  task automatic step(input bit up);
    phase_q = up ? phase_q + 1 : phase_q + 3;
    {quad_a_out, quad_b_out} = seq[phase_q % 4];
    #40;
  endtask

  // =============================================
  // frame latched at its first falling edge so a bench update cannot tear it
  // a long high time restarts the frame, so a length mismatch cannot persist
  always @(negedge ssi_clk_in) begin
    if (bit_idx < 0 || $realtime - rise_t > IDLE_NS) begin
      word_q  = frame_in;
      bit_idx = int'(nbits_in);
    end
  end

  // msb first, new bit on each rising edge; line released high once the frame is over
  always @(posedge ssi_clk_in) begin
    rise_t = $realtime;
    if (bit_idx > 0) begin
      bit_idx--;
      ssi_data_out = word_q[bit_idx];
      if (bit_idx == 0) begin
        ssi_data_out <= #(IDLE_NS) 1'b1;
      end
    end
  end
endmodule

// ==== epp_top_tb.sv ====
`timescale 1ns/1ps
module epp_top_tb;
  import epp_pkg::*;
  // =============================================
  // pins and bookkeeping
  logic        clock_in, rst_in, link_clk_in, par_wr_in, par_err_out, quad_a_in, quad_b_in;
  logic        ssi_clk_out, ssi_data_in, store_req_in, store_enable_out, store_go_out;
  logic [7:0]  par_sel_in, supply_sel_out, nb;
  logic [15:0] interp_frac_in, rotor_angle_out;
  logic [31:0] par_wdata_in, par_rdata_out, position_out, velocity_out, datum_value_out;
  logic [31:0] frame_q, mk, off, e, v;
  logic        cd, dir;
  int          err_total = 0, compares = 0, seed = 51792, cnt_q = 0, cyc_n = 0;

  epp_top #(.VEL_CYCLES(16), .MONO_CYCLES(4)) epp_top_i (.clock_in(clock_in), .rst_in(rst_in),
    .link_clk_in(link_clk_in), .par_sel_in(par_sel_in), .par_wr_in(par_wr_in), .par_wdata_in(par_wdata_in),
    .par_rdata_out(par_rdata_out), .par_err_out(par_err_out), .quad_a_in(quad_a_in), .quad_b_in(quad_b_in),
    .interp_frac_in(interp_frac_in), .ssi_clk_out(ssi_clk_out), .ssi_data_in(ssi_data_in),
    .store_req_in(store_req_in), .position_out(position_out), .velocity_out(velocity_out),
    .rotor_angle_out(rotor_angle_out), .supply_sel_out(supply_sel_out), .datum_value_out(datum_value_out),
    .store_enable_out(store_enable_out), .store_go_out(store_go_out));
  epp_enc_model epp_enc_model_i (.ssi_clk_in(ssi_clk_out), .ssi_data_out(ssi_data_in), .frame_in(frame_q),
    .nbits_in(nb), .quad_a_out(quad_a_in), .quad_b_out(quad_b_in));

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // link clock phase deliberately unrelated to the system clock
  initial begin
    link_clk_in = 1'b0;
    #13;
    forever #32 link_clk_in = ~link_clk_in;
  end
  always @(posedge clock_in) begin
    cyc_n++;
    if (cyc_n == 100000) begin
      err_total++;
      close_out();
    end
  end

  // =============================================
  // shared tasks
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // idle cycle after each write so the strobe never re-rises in the same step
  task automatic wr(input logic [7:0] sel, input logic [31:0] val, input logic bad);
    par_sel_in   = sel;
    par_wdata_in = val;
    par_wr_in    = 1'b1;
    cyc(1);
    par_wr_in    = 1'b0;
    chk("write error flag", {31'h0, bad}, {31'h0, par_err_out});
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] sel, output logic [31:0] val);
    par_sel_in = sel;
    cyc(1);
    val = par_rdata_out;
  endtask
  task automatic chk_defaults();
    logic [7:0]  sels [11] = '{SI_SUPPLY, SI_TYPE, SI_LINES, SI_DIR, SI_RES, SI_NBITS, SI_CODING, SI_MASK,
                               SI_OFFSET, SI_STORE, SI_DATUM};
    logic [31:0] vals [11] = '{32'(RST_SUPPLY), 32'(RST_TYPE), RST_LINES, 32'(RST_DIR), 32'(RST_RES),
                               32'(RST_NBITS), 32'(RST_CODING), RST_MASK, RST_OFFSET, 32'(RST_STORE), RST_DATUM};
    logic [31:0] r;
    for (int i = 0; i < 11; i++) begin
      rd(sels[i], r);
      chk("register default", vals[i], r);
    end
  endtask
  // reversal turns the counting direction; a count already held keeps its value
  task automatic quad_chk(input int sh, input int lg, input logic [31:0] o);
    logic [31:0] d;
    d = 32'(cnt_q);
    cyc(8);
    chk("position", (d << sh) - o, position_out);
    chk("rotor angle", {16'h0, 16'(d << (16 - lg))}, {16'h0, rotor_angle_out});
  endtask
  task automatic steps(input int n, input int mode);
    bit up;
    repeat (n) begin
      up = (mode == 2) ? 1'($random(seed)) : 1'(mode);
      epp_enc_model_i.step(up);
      cnt_q += (up != dir) ? 1 : -1;
    end
  endtask
  function automatic logic [31:0] ssi_val(logic [31:0] w, logic [31:0] m, logic [7:0] n, logic c);
    logic [31:0] r;
    int          j;
    r = 32'h0;
    j = 0;
    if (n < 8'h20) m &= (32'h1 << n) - 32'h1;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) begin
        r[j] = w[i];
        j++;
      end
    end
    if (c == 1'b0) for (int i = 30; i >= 0; i--) r[i] ^= r[i+1];
    return r;
  endfunction

  // =============================================
  // main sequence
  initial begin
    {par_sel_in, par_wr_in, par_wdata_in, store_req_in, interp_frac_in} = '0;
    frame_q = 32'h0;
    dir     = 1'b0;
    nb      = RST_NBITS;
    rst_in  = 1'b1;
    // held longer than two cycles: the link side needs three of its own edges
    cyc(40);
    rst_in  = 1'b0;
    cyc(4);
    chk_defaults();
    chk("supply pins", 32'h5, {24'h0, supply_sel_out});
    wr(SI_SUPPLY, 32'h7, 1'b1); wr(SI_TYPE, 32'h6, 1'b1); wr(SI_DIR, 32'h2, 1'b1); wr(SI_RES, 32'h1, 1'b1);
    wr(SI_RES, 32'h20, 1'b1); wr(SI_NBITS, 32'h1, 1'b1); wr(SI_NBITS, 32'h21, 1'b1);
    wr(SI_CODING, 32'h2, 1'b1); wr(SI_STORE, 32'h2, 1'b1); wr(SI_POS, 32'h0, 1'b1); wr(SI_ANGLE, 32'h0, 1'b1);
    wr(8'h20, 32'h0, 1'b1);
    chk_defaults();
    wr(SI_SUPPLY, 32'h8, 1'b0);
    chk("supply pins", 32'h8, {24'h0, supply_sel_out});
    $display("test registers done");
    interp_frac_in = 16'($random(seed));
    wr(SI_TYPE, 32'h1, 1'b0);
    wr(SI_RES, 32'h2, 1'b0);
    steps(24, 2);
    quad_chk(0, 12, 32'h0);
    steps(5, 1);
    quad_chk(0, 12, 32'h0);
    wr(SI_RES, 32'hA, 1'b0);
    quad_chk(8, 12, 32'h0);
    wr(SI_DIR, 32'h1, 1'b0);
    dir = 1'b1;
    quad_chk(8, 12, 32'h0);
    fork
      steps(8, 1);
      begin
        cyc(52);
        chk("velocity", -32'h200, velocity_out);
      end
    join
    quad_chk(8, 12, 32'h0);
    rd(SI_POS, off);
    wr(SI_OFFSET, off, 1'b0);
    quad_chk(8, 12, off);
    chk("zeroed position", 32'h0, position_out);
    steps(3, 0);
    // revolution count must be zero before the line count shrinks under it
    while (cnt_q < 0) begin
      steps(1, 0);
    end
    wr(SI_LINES, 32'h1, 1'b0);
    quad_chk(8, 2, off);
    wr(SI_TYPE, 32'h2, 1'b0);
    cyc(8);
    chk("interpolated position", ((32'(cnt_q) << 8) | 32'(16'(-interp_frac_in) >> 8)) - off, position_out);
    $display("test quadrature done");
    wr(SI_TYPE, 32'h3, 1'b0);
    for (int k = 0; k < 6; k++) begin
      nb  = (k == 0) ? 8'h20 : (k == 1) ? 8'h02 : 8'(2 + {$random(seed)} % 31);
      mk  = (k == 2) ? 32'hFFFFFFFF : $random(seed);
      cd  = 1'($random(seed));
      dir = 1'($random(seed));
      off = (k < 2) ? 32'h0 : $random(seed);
      wr(SI_NBITS, 32'(nb), 1'b0); wr(SI_CODING, 32'(cd), 1'b0); wr(SI_MASK, mk, 1'b0);
      wr(SI_DIR, 32'(dir), 1'b0); wr(SI_OFFSET, off, 1'b0);
      frame_q = $random(seed);
      e = ssi_val(frame_q, mk, nb, cd);
      e = (dir ? -e : e) - off;
      for (int t = 0; t < 16000 && position_out !== e; t++) cyc(1);
      chk("serial position", e, position_out);
    end
    cyc(40);
    chk("velocity at rest", 32'h0, velocity_out);
    $display("test serial done");
    store_req_in = 1'b1;
    cyc(1);
    chk("store pulse", 32'h0, {31'h0, store_go_out});
    store_req_in = 1'b0;
    wr(SI_STORE, 32'h1, 1'b0);
    store_req_in = 1'b1;
    cyc(1);
    store_req_in = 1'b0;
    chk("store pulse", 32'h1, {31'h0, store_go_out});
    chk("store enable", 32'h1, {31'h0, store_enable_out});
    cyc(1);
    chk("store pulse", 32'h0, {31'h0, store_go_out});
    off = $random(seed);
    wr(SI_DATUM, off, 1'b0);
    rd(SI_DATUM, v);
    chk("datum readback", off, v);
    chk("datum pins", off, datum_value_out);
    $display("test storage and datum done");
    close_out();
  end
endmodule
